// *** logic/level_cfg_pkg.sv ***
// constants, types and helpers shared by the interrupt level configuration block
package level_cfg_pkg;

  // register byte offsets on the apb bus
  localparam logic [11:0] level_off = 12'h000;
  localparam logic [11:0] status_off = 12'h004;
  localparam logic [11:0] mask_off = 12'h008;
  localparam logic [11:0] request_off = 12'h00c;

  // level field layout
  localparam int level_w = 3;
  localparam int ecc_lsb = 0;
  localparam int wto_lsb = 8;
  localparam logic [2:0] level_reset = 3'h0;
  localparam logic [2:0] level_off_code = 3'h0;

  // status and mask layout: event bits then overrun bits
  localparam int src_n = 2;
  localparam int src_ecc = 0;
  localparam int src_wto = 1;
  localparam int ovr_lsb = 2;
  localparam int stat_w = 4;
  localparam logic [3:0] stat_reset = 4'h0;
  localparam logic [3:0] mask_reset = 4'h0;

  typedef logic [2:0] level_t;

  typedef enum logic [2:0] {
    sel_level,
    sel_status,
    sel_mask,
    sel_request,
    sel_none
  } reg_sel_t;

  typedef enum logic {
    bus_idle,
    bus_access
  } bus_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } apb_rsp_t;

  // address decode, used for both the read answer and the write action
  function automatic reg_sel_t decode(input logic [11:0] addr);
    if (addr == level_off) begin
      decode = sel_level;
    end else if (addr == status_off) begin
      decode = sel_status;
    end else if (addr == mask_off) begin
      decode = sel_mask;
    end else if (addr == request_off) begin
      decode = sel_request;
    end else begin
      decode = sel_none;
    end
  endfunction : decode

  // assemble the level word; every other bit reads zero
  function automatic logic [31:0] level_word(input level_t ecc, input level_t wto);
    level_word = 32'h0;
    level_word[ecc_lsb +: level_w] = ecc;
    level_word[wto_lsb +: level_w] = wto;
  endfunction : level_word

endpackage : level_cfg_pkg

// *** logic/source_gate.sv ***
// one interrupt source: sticky event flag, overrun flag and level-gated request
`timescale 1ns/1ps
module source_gate
  import level_cfg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic event_pulse,
  input wire level_cfg_pkg::level_t level,
  input wire logic clear,
  output logic pending,
  output logic overrun,
  output logic request
);

  typedef struct packed {
    logic pending;
    logic overrun;
    logic request;
  } gate_state_t;

  gate_state_t state_reg;
  gate_state_t state_next;

  // set beats clear so an event in the clearing cycle is kept
  always_comb begin
    state_next = state_reg;
    if (clear) begin
      state_next.pending = 1'b0;
      state_next.overrun = 1'b0;
    end
    if (event_pulse) begin
      state_next.pending = 1'b1;
      state_next.overrun = state_reg.pending & ~clear;
    end
    // code zero keeps the source off the priority path
    state_next.request = state_next.pending && (level != level_off_code);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pending = state_reg.pending;
  assign overrun = state_reg.overrun;
  assign request = state_reg.request;

endmodule : source_gate

// *** logic/interrupt_level_config.sv ***
// apb register block holding the ecc and write-timeout interrupt levels
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module interrupt_level_config
  import level_cfg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire level_cfg_pkg::apb_req_t apb_req,
  output level_cfg_pkg::apb_rsp_t apb_rsp,
  input wire logic ecc_error_event,
  input wire logic write_timeout_event,
  output level_cfg_pkg::level_t ecc_error_level,
  output level_cfg_pkg::level_t write_timeout_level,
  output logic ecc_error_req,
  output logic write_timeout_req,
  output logic irq
);

  // all block state except the gates' sticky flags and request flops in one record
  typedef struct packed {
    bus_state_t bus;
    apb_rsp_t rsp;
    level_t ecc_level;
    level_t wto_level;
    logic [3:0] mask;
    logic irq;
  } blk_state_t;

  blk_state_t state_reg;
  blk_state_t state_next;

  // per-source wiring between this block and the gates
  logic [1:0] src_event;
  logic [1:0] src_pending;
  logic [1:0] src_overrun;
  logic [1:0] src_request;
  level_t src_level [2];
  logic status_clear;
  logic [3:0] status_now;

  // access-phase handshake seen by the slave
  logic access_done;
  logic write_done;
  logic read_done;
  reg_sel_t access_sel;

  assign src_event[src_ecc] = ecc_error_event;
  assign src_event[src_wto] = write_timeout_event;

  // the gates see the stored fields, so a new level acts one cycle after the write
  assign src_level[src_ecc] = state_reg.ecc_level;
  assign src_level[src_wto] = state_reg.wto_level;

  // status word: event bits low, overrun bits above
  assign status_now = {src_overrun, src_pending};

  // a write or read takes effect only on the edge that completes the access
  assign access_done = apb_req.psel && apb_req.penable && state_reg.rsp.pready;
  assign write_done = access_done && apb_req.pwrite;
  assign read_done = access_done && !apb_req.pwrite;
  assign access_sel = decode(apb_req.paddr);

  // a completed read of status clears only the sources whose pending bit its answer reported, so an
  // event landing between the setup and the access edge is not lost
  assign status_clear = read_done && (access_sel == sel_status);

  // one gate per source keeps the sticky flag and the forwarded request
  for (genvar i = 0; i < src_n; i++) begin : g_src
    source_gate u_gate (
      .pclk(pclk),
      .presetn(presetn),
      .event_pulse(src_event[i]),
      .level(src_level[i]),
      .clear(status_clear && state_reg.rsp.prdata[i]),
      .pending(src_pending[i]),
      .overrun(src_overrun[i]),
      .request(src_request[i])
    );
  end

  // read mux for the setup cycle; the answer is registered for the access phase
  function automatic logic [31:0] read_value(input reg_sel_t sel);
    logic [31:0] word;
    word = 32'h0;
    if (sel == sel_level) begin
      word = level_word(state_reg.ecc_level, state_reg.wto_level);
    end else if (sel == sel_status) begin
      word[stat_w-1:0] = status_now;
    end else if (sel == sel_mask) begin
      word[stat_w-1:0] = state_reg.mask;
    end else if (sel == sel_request) begin
      word[src_n-1:0] = src_request;
    end
    read_value = word;
  endfunction : read_value

  // next-state logic: bus handshake, register writes and interrupt line
  always_comb begin
    state_next = state_reg;
    case (state_reg.bus)
      bus_idle: begin
        state_next.rsp.pready = 1'b0;
        // setup cycle: prepare the answer so it stands throughout the access phase
        if (apb_req.psel && !apb_req.penable) begin
          state_next.bus = bus_access;
          state_next.rsp.pready = 1'b1;
          state_next.rsp.pslverr = (access_sel == sel_none);
          if (apb_req.pwrite) begin
            state_next.rsp.prdata = 32'h0;
          end else begin
            state_next.rsp.prdata = read_value(access_sel);
          end
        end
      end
      bus_access: begin
        // the answer lasts one access cycle with no wait states
        if (access_done) begin
          state_next.bus = bus_idle;
          state_next.rsp.pready = 1'b0;
          state_next.rsp.pslverr = 1'b0;
          state_next.rsp.prdata = 32'h0;
        end else if (!apb_req.psel) begin
          // master walked away: drop the answer rather than hang
          state_next.bus = bus_idle;
          state_next.rsp.pready = 1'b0;
          state_next.rsp.pslverr = 1'b0;
          state_next.rsp.prdata = 32'h0;
        end
      end
      default: begin
        state_next.bus = bus_idle;
        state_next.rsp.pready = 1'b0;
      end
    endcase

    // register writes; status and request views are read only
    if (write_done) begin
      if (access_sel == sel_level) begin
        // only the two level fields are stored, reserved bits are dropped
        state_next.ecc_level = apb_req.pwdata[ecc_lsb +: level_w];
        state_next.wto_level = apb_req.pwdata[wto_lsb +: level_w];
      end else if (access_sel == sel_mask) begin
        state_next.mask = apb_req.pwdata[stat_w-1:0];
      end
    end

    // level line: high while any unmasked sticky bit stands
    state_next.irq = |(status_now & state_reg.mask);
  end

  // single register stage for the whole record; the gates keep their own flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.bus <= bus_idle;
      state_reg.rsp <= '0;
      state_reg.ecc_level <= level_reset;
      state_reg.wto_level <= level_reset;
      state_reg.mask <= mask_reset;
      state_reg.irq <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs come straight from flops
  assign apb_rsp = state_reg.rsp;
  assign ecc_error_level = state_reg.ecc_level;
  assign write_timeout_level = state_reg.wto_level;
  assign ecc_error_req = src_request[src_ecc];
  assign write_timeout_req = src_request[src_wto];
  assign irq = state_reg.irq;

endmodule : interrupt_level_config

// *** sim/level_cfg_properties.sv ***
// checker for the interrupt level configuration block ports
`timescale 1ns/1ps
module level_cfg_checker
  import level_cfg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire level_cfg_pkg::apb_req_t apb_req,
  input wire level_cfg_pkg::apb_rsp_t apb_rsp,
  input wire logic ecc_error_event,
  input wire logic write_timeout_event,
  input wire level_cfg_pkg::level_t ecc_error_level,
  input wire level_cfg_pkg::level_t write_timeout_level,
  input wire logic ecc_error_req,
  input wire logic write_timeout_req,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a completed access to the level word
  logic lvl_hit;
  assign lvl_hit = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.paddr == level_off;
  chk_wto_store: assert property (lvl_hit && apb_req.pwrite |=>
    write_timeout_level == $past(apb_req.pwdata[10:8])) else $error("wto level not stored");
  chk_ecc_store: assert property (lvl_hit && apb_req.pwrite |=>
    ecc_error_level == $past(apb_req.pwdata[2:0])) else $error("ecc level not stored");
  chk_off_silent: assert property (ecc_error_level == 3'h0 && $past(ecc_error_level) == 3'h0
    |-> !ecc_error_req) else $error("disabled source forwarded");
  chk_level_fwd: assert property (ecc_error_event && ecc_error_level != 3'h0
    |=> ecc_error_req) else $error("enabled source not forwarded");
  chk_reset_zero: assert property ($rose(presetn) |-> ecc_error_level == 3'h0 &&
    write_timeout_level == 3'h0) else $error("levels not zero after reset");
  chk_wto_silent: assert property (write_timeout_level == 3'h0 &&
    $past(write_timeout_level) == 3'h0 |-> !write_timeout_req) else $error("wto source forwarded");
  chk_wto_fwd: assert property (write_timeout_event && write_timeout_level != 3'h0
    |=> write_timeout_req) else $error("enabled wto source not forwarded");
  chk_reserved_zero: assert property (lvl_hit && !apb_req.pwrite |-> apb_rsp.prdata ==
    {21'h0, write_timeout_level, 5'h0, ecc_error_level}) else $error("level word read wrong");
endmodule : level_cfg_checker

bind interrupt_level_config level_cfg_checker u_level_cfg_checker (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .ecc_error_event(ecc_error_event),
  .write_timeout_event(write_timeout_event), .ecc_error_level(ecc_error_level),
  .write_timeout_level(write_timeout_level), .ecc_error_req(ecc_error_req),
  .write_timeout_req(write_timeout_req), .irq(irq));

// *** sim/core_model.sv ***
// processor core model picking the highest forwarded request level
`timescale 1ns/1ps
module core_model
  import level_cfg_pkg::*;
(
  input wire level_cfg_pkg::level_t ecc_error_level,
  input wire level_cfg_pkg::level_t write_timeout_level,
  input wire logic ecc_error_req,
  input wire logic write_timeout_req,
  output level_cfg_pkg::level_t top_level
);
  // level 0 never wins; codes compare as plain binary numbers
  always_comb begin
    top_level = 3'h0;
    if (ecc_error_req && ecc_error_level > top_level) top_level = ecc_error_level;
    if (write_timeout_req && write_timeout_level > top_level) top_level = write_timeout_level;
  end
endmodule : core_model

// *** sim/interrupt_level_config_bench.sv ***
// register-level bench for the interrupt level configuration block
`timescale 1ns/1ps
module interrupt_level_config_bench;
  import level_cfg_pkg::*;
  logic pclk, presetn, ecc_ev, wto_ev, ecc_req, wto_req, irq, e;
  apb_req_t req;
  apb_rsp_t rsp;
  level_t ecc_lvl, wto_lvl, top;
  logic [31:0] q;
  int bad_count, comparisons;
  interrupt_level_config u_interrupt_level_config (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .apb_rsp(rsp), .ecc_error_event(ecc_ev), .write_timeout_event(wto_ev),
    .ecc_error_level(ecc_lvl), .write_timeout_level(wto_lvl), .ecc_error_req(ecc_req),
    .write_timeout_req(wto_req), .irq(irq));
  core_model u_core_model (.ecc_error_level(ecc_lvl), .write_timeout_level(wto_lvl),
    .ecc_error_req(ecc_req), .write_timeout_req(wto_req), .top_level(top));
  // free-running 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic complete_run();
    $display("counts: %0d compared, %0d mismatched", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; pready is sampled at the rising edge, before that edge's updates
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    q = rsp.prdata;
    e = rsp.pslverr;
    // release on the completing edge; the next call waits one edge first
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (rsp.pready !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED at %0t: no pready", $time);
      complete_run();
    end
  endtask : xfer
  // events are single-cycle pulses; outputs are looked at three cycles on
  task automatic pulse(input logic e0, input logic e1);
    @(posedge pclk);
    ecc_ev <= e0;
    wto_ev <= e1;
    @(posedge pclk);
    ecc_ev <= 1'b0;
    wto_ev <= 1'b0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask : pulse
  initial begin
    presetn = 1'b0;
    ecc_ev = 1'b0;
    wto_ev = 1'b0;
    req = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, level_off, 32'h0); chk(q, 32'h0);
    $display("test reset values done");
    // every code in both fields, reserved bits written as ones
    for (int c = 0; c < 8; c++) begin
      xfer(1'b1, level_off, 32'hffff_f8f8 | (32'(c) << 8) | 32'(7 - c));
      xfer(1'b0, level_off, 32'h0); chk(q, (32'(c) << 8) | 32'(7 - c));
      chk({ecc_lvl, wto_lvl}, {3'(7 - c), 3'(c)});
    end
    $display("test level codes done");
    xfer(1'b1, level_off, 32'h0000_0500);
    xfer(1'b1, mask_off, 32'h3);
    pulse(1'b1, 1'b1);
    chk({ecc_req, wto_req, irq, top}, {3'b011, 3'h5});
    xfer(1'b0, status_off, 32'h0); chk(q, 32'h3);
    pulse(1'b0, 1'b0);
    chk({wto_req, irq}, 2'b00);
    xfer(1'b1, mask_off, 32'h0);
    pulse(1'b0, 1'b1);
    chk({wto_req, irq, top}, {2'b10, 3'h5});
    xfer(1'b0, status_off, 32'h0); chk(q, 32'h2);
    xfer(1'b0, 12'h010, 32'h0); chk({e, q}, {1'b1, 32'h0});
    $display("test interrupt path done");
    // ecc source enabled, write-timeout source off; a second ecc event sets overrun
    xfer(1'b1, level_off, 32'h0000_0003);
    pulse(1'b1, 1'b1);
    chk({ecc_req, wto_req, top}, {2'b10, 3'h3});
    pulse(1'b1, 1'b0);
    xfer(1'b0, request_off, 32'h0); chk(q, 32'h1);
    xfer(1'b0, status_off, 32'h0); chk(q, 32'h7);
    pulse(1'b0, 1'b0);
    chk({ecc_req, wto_req, irq}, 3'b000);
    $display("test overrun path done");
    // reset in mid-run must bring both fields back to zero
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, level_off, 32'h0); chk(q, 32'h0);
    chk({ecc_lvl, wto_lvl, ecc_req, wto_req}, 8'h00);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule : interrupt_level_config_bench
